// >>> hdl/flash_bus_cycle.sv
`timescale 1ns/10ps
`include "flash_ctrl_defs.svh"
module flash_bus_cycle (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Request
    input wire logic start,
    input wire logic write,
    input wire logic [21:0] addr,
    input wire logic [15:0] wdata,
    output logic busy,
    output logic done,
    output logic [15:0] rdata,
    // Flash side
    input wire logic [15:0] dq_sync,
    output flash_ctrl_pkg::flash_pins_s pins
);
    logic is_wr; // Current cycle is a write
    logic [2:0] ph; // Phase within the cycle

    // One write or read cycle on the flash pins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'b0;
            done <= 1'b0;
            is_wr <= 1'b0;
            ph <= 3'h0;
            rdata <= 16'h0000;
            pins <= {22'h000000, 16'h0000, 4'hF};
        end else begin
            done <= 1'b0;
            if (!busy) begin
                // Address, chip enable and data set up together
                if (start) begin
                    busy <= 1'b1;
                    ph <= 3'h0;
                    is_wr <= write;
                    pins.addr <= addr;
                    pins.ce_b <= 1'b0;
                    if (write) begin
                        pins.dq_out <= wdata;
                        pins.dq_oe_b <= 1'b0;
                    end else begin
                        pins.oe_b <= 1'b0;
                    end
                end
            end else begin
                ph <= ph + 3'h1;
                if (is_wr) begin
                    // Strobe low one cycle; data latches on its rise
                    case (ph)
                        3'h0: pins.we_b <= 1'b0;
                        3'h1: pins.we_b <= 1'b1;
                        default: begin
                            pins.ce_b <= 1'b1;
                            pins.dq_oe_b <= 1'b1;
                            busy <= 1'b0;
                            done <= 1'b1;
                        end
                    endcase
                end else if (ph == 3'(`RD_SAMPLE_PH)) begin
                    // Sample late enough to cover the input synchroniser
                    rdata <= dq_sync;
                    pins.ce_b <= 1'b1;
                    pins.oe_b <= 1'b1;
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end

    AST_WE_ONE_CYCLE: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(pins.we_b) |=> pins.we_b && !pins.dq_oe_b)
        else $error("write strobe not exactly one cycle");
    AST_NO_CONTENTION: assert property (@(posedge clk) disable iff (!rst_b)
        !pins.oe_b |-> pins.dq_oe_b && pins.we_b)
        else $error("data driven during a read");
    AST_READ_LEN: assert property (@(posedge clk) disable iff (!rst_b)
        start && !busy && !write |-> ##5 done)
        else $error("read cycle length wrong");
    AST_WRITE_LEN: assert property (@(posedge clk) disable iff (!rst_b)
        start && !busy && write |-> ##4 done && pins.ce_b)
        else $error("write cycle length wrong");
endmodule : flash_bus_cycle

// >>> hdl/flash_ctrl_defs.svh
`ifndef FLASH_CTRL_DEFS_SVH
`define FLASH_CTRL_DEFS_SVH
// Summary of operation
// - Host resumes program; repeats ignored, resuspend allowed
// - Chip erase is six ordered write cycles
// - Sector erase: unlocks, setup, unlocks, sector command
// - Extra sector entries within 50 us gaps
// - Host resumes erase; repeats ignored, resuspend allowed
// - Only low address bits 555/2AA are decoded

// Clock period
`define CLK_NS 100
// Sector acceptance window, longest time rounds down
`define WIN_NS 50000
`define WIN_CYC ((`WIN_NS) / (`CLK_NS))
// Host closes its window early: load lag plus next strobe latency
`define WIN_MARGIN_CYC 8
// Hardware reset pulse, least time rounds up
`define HWRST_NS 500
`define HWRST_CYC (((`HWRST_NS) + (`CLK_NS) - 1) / (`CLK_NS))

// Bus cycle phases
`define WR_LAST_PH 2
`define RD_SAMPLE_PH 3

// Register offsets
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_WDATA 8'h08
`define REG_RDATA 8'h0C
`define REG_STATUS 8'h10

// Status field positions
`define ST_BUSY 0
`define ST_ERR 1
`define ST_WIN 2
`define ST_POLL 3
`define ST_TOGGLE 4
`define ST_ETOGGLE 5
`define ST_EWIN 6
`define ST_SUSP 7

// Command cycle words
`define UNLOCK_A1 11'h555
`define UNLOCK_A2 11'h2AA
`define CODE_AA 8'hAA
`define CODE_55 8'h55
`define CODE_SETUP 8'h80
`define CODE_CHIP 8'h10
`define CODE_SECTOR 8'h30
`define CODE_SUSPEND 8'hB0
`define CODE_RESUME 8'h30
`define CODE_RESET 8'hF0
`define CODE_PROGRAM 8'hA0
`define CODE_ID 8'h90

// Sector field of the flash address
`define SECT_HI 21
`define SECT_LO 15
`endif

// >>> hdl/flash_ctrl_pkg.sv
package flash_ctrl_pkg;
    // Operations that software orders through the control register
    typedef enum logic [3:0] {
        OP_NONE, OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_SECTOR_ADD,
        OP_SUSPEND, OP_RESUME, OP_RESET, OP_PROGRAM, OP_ID_ENTER,
        OP_READ, OP_HW_RESET
    } op_e;
    // Flash pin outputs travel together
    typedef struct packed {
        logic [21:0] addr;
        logic [15:0] dq_out;
        logic dq_oe_b;
        logic ce_b;
        logic oe_b;
        logic we_b;
    } flash_pins_s;
    // One bus word of a command sequence
    typedef struct packed {
        logic [21:0] addr;
        logic [15:0] data;
    } bus_word_s;
endpackage : flash_ctrl_pkg

// >>> hdl/flash_erase_ctrl.sv
`timescale 1ns/10ps
`include "flash_ctrl_defs.svh"
module flash_erase_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    // AXI4-Lite write response
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // Flash pins
    output flash_ctrl_pkg::flash_pins_s flash_pins,
    input wire logic [15:0] flash_dq_in,
    output logic flash_reset_b
);
    typedef enum {ST_IDLE, ST_ISSUE, ST_WAIT, ST_HWRST} state_e;

    logic rst_meta_b; // Reset synchroniser first stage
    logic rst_sync_b; // Released reset used everywhere
    logic [15:0] dq_meta; // Data synchroniser first stage
    logic [15:0] dq_sync; // Synchronised data bus
    state_e state; // Sequencer state
    flash_ctrl_pkg::op_e op; // Operation in progress
    logic [2:0] step; // Bus word within the sequence
    logic [21:0] addr_reg; // Target address
    logic [15:0] wdata_reg; // Program data
    logic [15:0] rdata_reg; // Last word read
    logic [15:0] prev_rdata; // Word read before that
    logic err; // Sticky refused-order flag
    logic susp; // An erase or program is held suspended
    logic [9:0] win_cnt; // Cycles left in the sector window
    logic [3:0] hw_cnt; // Hardware reset pulse counter
    logic cyc_start; // Start a bus cycle
    logic cyc_done; // Bus cycle finished
    logic [15:0] cyc_rdata; // Word returned by the engine
    flash_ctrl_pkg::bus_word_s word; // Current bus word
    logic wr_go; // Write address and data taken
    logic go; // Control register written with an op
    logic window_open; // Host believes the window still runs
    logic last_step; // Current word ends the sequence
    logic [31:0] status; // Status register image

    // Number of bus words in each operation
    function automatic logic [2:0] op_len(flash_ctrl_pkg::op_e o);
        case (o)
            flash_ctrl_pkg::OP_CHIP_ERASE: op_len = 3'h6;
            flash_ctrl_pkg::OP_SECTOR_ERASE: op_len = 3'h6;
            flash_ctrl_pkg::OP_PROGRAM: op_len = 3'h4;
            flash_ctrl_pkg::OP_ID_ENTER: op_len = 3'h3;
            default: op_len = 3'h1;
        endcase
    endfunction : op_len

    // Address and data of one word of a command sequence
    function automatic flash_ctrl_pkg::bus_word_s seq_word(
        flash_ctrl_pkg::op_e o, logic [2:0] s, logic [21:0] a,
        logic [15:0] d);
        logic [21:0] sect;
        logic [7:0] code3;
        // Sector select address keeps only the sector bits
        sect = {a[`SECT_HI:`SECT_LO], 15'h0000};
        code3 = (o == flash_ctrl_pkg::OP_PROGRAM) ? `CODE_PROGRAM :
            (o == flash_ctrl_pkg::OP_ID_ENTER) ? `CODE_ID : `CODE_SETUP;
        seq_word = {22'h000000, 16'h0000};
        case (o)
            flash_ctrl_pkg::OP_SECTOR_ADD:
                seq_word = {sect, 8'h00, `CODE_SECTOR};
            flash_ctrl_pkg::OP_SUSPEND:
                seq_word.data = {8'h00, `CODE_SUSPEND};
            flash_ctrl_pkg::OP_RESUME:
                seq_word.data = {8'h00, `CODE_RESUME};
            flash_ctrl_pkg::OP_RESET:
                seq_word.data = {8'h00, `CODE_RESET};
            flash_ctrl_pkg::OP_READ:
                seq_word.addr = a;
            default: begin
                // Unlock and setup words keep upper address bits and upper data byte zero
                case (s)
                    3'h0, 3'h3: seq_word = {11'h000, `UNLOCK_A1,
                        8'h00, `CODE_AA};
                    3'h1, 3'h4: seq_word = {11'h000, `UNLOCK_A2,
                        8'h00, `CODE_55};
                    3'h2: seq_word = {11'h000, `UNLOCK_A1, 8'h00, code3};
                    default: begin
                        // Sixth word: chip or sector command; program ends at step 3 and never sends its address and data word
                        if (o == flash_ctrl_pkg::OP_CHIP_ERASE)
                            seq_word = {11'h000, `UNLOCK_A1, 8'h00,
                                `CODE_CHIP};
                        else if (o == flash_ctrl_pkg::OP_SECTOR_ERASE)
                            seq_word = {sect, 8'h00, `CODE_SECTOR};
                        else
                            seq_word = {a, d};
                    end
                endcase
            end
        endcase
    endfunction : seq_word

    // Reset release through two flip-flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    // Pin data passes two flip-flops before use
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            dq_meta <= 16'h0000;
            dq_sync <= 16'h0000;
        end else begin
            dq_meta <= flash_dq_in;
            dq_sync <= dq_meta;
        end
    end

    // Write channel: both taken together, one response outstanding
    assign wr_go = s_awvalid && s_wvalid && !s_bvalid;
    assign s_awready = wr_go;
    assign s_wready = wr_go;
    assign s_arready = !s_rvalid;
    assign go = wr_go && s_awaddr == `REG_CTRL && s_wstrb[0];
    assign window_open = win_cnt != 10'h000;
    assign last_step = step == op_len(op) - 3'h1;
    assign cyc_start = state == ST_ISSUE;
    assign word = seq_word(op, step, addr_reg, wdata_reg);

    // Write response; unmapped offsets answer SLVERR
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            s_bvalid <= 1'b0;
            s_bresp <= 2'h0;
        end else if (wr_go) begin
            s_bvalid <= 1'b1;
            if (s_awaddr == `REG_CTRL || s_awaddr == `REG_ADDR ||
                s_awaddr == `REG_WDATA || s_awaddr == `REG_STATUS)
                s_bresp <= 2'h0;
            else
                s_bresp <= 2'h2;
        end else if (s_bready) begin
            s_bvalid <= 1'b0;
        end
    end

    // Address and program data registers
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            addr_reg <= 22'h000000;
            wdata_reg <= 16'h0000;
        end else if (wr_go && s_awaddr == `REG_ADDR) begin
            addr_reg <= s_wdata[21:0];
        end else if (wr_go && s_awaddr == `REG_WDATA) begin
            wdata_reg <= s_wdata[15:0];
        end
    end

    // Refused orders set err; a new refusal beats the clear
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            err <= 1'b0;
        end else if (go && (state != ST_IDLE ||
            (s_wdata[3:0] == 4'(flash_ctrl_pkg::OP_SECTOR_ADD) &&
            !window_open))) begin
            err <= 1'b1;
        end else if (wr_go && s_awaddr == `REG_STATUS &&
            s_wdata[`ST_ERR]) begin
            err <= 1'b0;
        end
    end

    // Command sequencer
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state <= ST_IDLE;
            op <= flash_ctrl_pkg::OP_NONE;
            step <= 3'h0;
            hw_cnt <= 4'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    // Late sector entries are refused, not sent
                    if (go && !(s_wdata[3:0] ==
                        4'(flash_ctrl_pkg::OP_SECTOR_ADD) && !window_open))
                    begin
                        op <= flash_ctrl_pkg::op_e'(s_wdata[3:0]);
                        step <= 3'h0;
                        hw_cnt <= 4'(`HWRST_CYC);
                        if (s_wdata[3:0] == 4'(flash_ctrl_pkg::OP_HW_RESET))
                            state <= ST_HWRST;
                        else if (s_wdata[3:0] != 4'(flash_ctrl_pkg::OP_NONE))
                            state <= ST_ISSUE;
                    end
                end
                ST_ISSUE: state <= ST_WAIT;
                ST_WAIT: begin
                    // Next word only after the previous strobe rose
                    if (cyc_done) begin
                        step <= step + 3'h1;
                        state <= last_step ? ST_IDLE : ST_ISSUE;
                    end
                end
                ST_HWRST: begin
                    // Pulse the reset pin; this aborts any erase
                    hw_cnt <= hw_cnt - 4'h1;
                    if (hw_cnt == 4'h1)
                        state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    assign flash_reset_b = state != ST_HWRST;

    // Sector window timer from the final strobe rise
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            win_cnt <= 10'h000;
        end else if (state == ST_WAIT && cyc_done && last_step &&
            (op == flash_ctrl_pkg::OP_SECTOR_ERASE ||
            op == flash_ctrl_pkg::OP_SECTOR_ADD)) begin
            win_cnt <= 10'(`WIN_CYC - `WIN_MARGIN_CYC);
        end else if (state == ST_HWRST || state == ST_ISSUE &&
            op != flash_ctrl_pkg::OP_SECTOR_ADD &&
            op != flash_ctrl_pkg::OP_READ) begin
            win_cnt <= 10'h000;
        end else if (window_open) begin
            win_cnt <= win_cnt - 10'h001;
        end
    end

    // Track suspension so software can see when resume is due
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            susp <= 1'b0;
        end else if (state == ST_HWRST) begin
            susp <= 1'b0;
        end else if (state == ST_WAIT && cyc_done) begin
            if (op == flash_ctrl_pkg::OP_SUSPEND)
                susp <= 1'b1;
            else if (op == flash_ctrl_pkg::OP_RESUME)
                susp <= 1'b0;
        end
    end

    // Read results; two reads in a row reveal toggling bits
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            rdata_reg <= 16'h0000;
            prev_rdata <= 16'h0000;
        end else if (state == ST_WAIT && cyc_done &&
            op == flash_ctrl_pkg::OP_READ) begin
            rdata_reg <= cyc_rdata;
            prev_rdata <= rdata_reg;
        end
    end

    // Status image: own state plus decoded low status lines
    always_comb begin
        status = 32'h00000000;
        status[`ST_BUSY] = state != ST_IDLE;
        status[`ST_ERR] = err;
        status[`ST_WIN] = window_open;
        status[`ST_POLL] = rdata_reg[7];
        status[`ST_TOGGLE] = rdata_reg[6] ^ prev_rdata[6];
        status[`ST_ETOGGLE] = rdata_reg[2] ^ prev_rdata[2];
        status[`ST_EWIN] = rdata_reg[3];
        status[`ST_SUSP] = susp;
    end

    // Read channel; unmapped offsets read zero with SLVERR
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            s_rvalid <= 1'b0;
            s_rdata <= 32'h00000000;
            s_rresp <= 2'h0;
        end else if (s_arvalid && !s_rvalid) begin
            s_rvalid <= 1'b1;
            s_rresp <= 2'h0;
            if (s_araddr == `REG_CTRL)
                s_rdata <= {28'h0000000, 4'(op)};
            else if (s_araddr == `REG_ADDR)
                s_rdata <= {10'h000, addr_reg};
            else if (s_araddr == `REG_WDATA)
                s_rdata <= {16'h0000, wdata_reg};
            else if (s_araddr == `REG_RDATA)
                s_rdata <= {16'h0000, rdata_reg};
            else if (s_araddr == `REG_STATUS)
                s_rdata <= status;
            else begin
                s_rdata <= 32'h00000000;
                s_rresp <= 2'h2;
            end
        end else if (s_rready) begin
            s_rvalid <= 1'b0;
        end
    end

    // Pin-level bus cycle engine
    flash_bus_cycle u_cycle (
        .clk(clk),
        .rst_b(rst_sync_b),
        .start(cyc_start),
        .write(op != flash_ctrl_pkg::OP_READ),
        .addr(word.addr),
        .wdata(word.data),
        .busy(),
        .done(cyc_done),
        .rdata(cyc_rdata),
        .dq_sync(dq_sync),
        .pins(flash_pins)
    );

    AST_CHIP_LAST: assert property (@(posedge clk) disable iff (!rst_sync_b)
        state == ST_ISSUE && op == flash_ctrl_pkg::OP_CHIP_ERASE &&
        step == 3'h5 |=> flash_pins.dq_out[7:0] == 8'h10 &&
        flash_pins.addr[10:0] == 11'h555)
        else $error("chip erase final word wrong");
    AST_SECTOR_ADDR: assert property (@(posedge clk)
        disable iff (!rst_sync_b)
        state == ST_ISSUE && op == flash_ctrl_pkg::OP_SECTOR_ERASE &&
        step == 3'h5 |=> flash_pins.addr[14:0] == 15'h0000 &&
        flash_pins.addr[21:15] == addr_reg[21:15])
        else $error("sector address not on sector bits");
    AST_UNLOCK_FIRST: assert property (@(posedge clk)
        disable iff (!rst_sync_b)
        state == ST_ISSUE && step == 3'h0 && op_len(op) > 3'h1 |=>
        flash_pins.addr == 22'h000555 && flash_pins.dq_out == 16'h00AA)
        else $error("first unlock word wrong");
    AST_LATE_REFUSED: assert property (@(posedge clk)
        disable iff (!rst_sync_b)
        state == ST_IDLE && go && !window_open &&
        s_wdata[3:0] == 4'h3 |=> err && state == ST_IDLE)
        else $error("late sector entry not refused");
    AST_WINDOW_START: assert property (@(posedge clk)
        disable iff (!rst_sync_b)
        state == ST_WAIT && cyc_done && last_step &&
        op == flash_ctrl_pkg::OP_SECTOR_ERASE |=> win_cnt == 10'h1EC)
        else $error("window not started at final strobe");
    AST_HWRST_PULSE: assert property (@(posedge clk)
        disable iff (!rst_sync_b)
        $fell(flash_reset_b) |-> !flash_reset_b[*5] ##1 flash_reset_b)
        else $error("hardware reset pulse length wrong");
    AST_BHOLD: assert property (@(posedge clk) disable iff (!rst_sync_b)
        s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
        else $error("write response dropped");
endmodule : flash_erase_ctrl

// >>> tb/flash_dev_model.sv
`timescale 1ns/10ps
module flash_dev_model (
    // Clock and pins
    input wire logic clk,
    input wire logic reset_b,
    input wire flash_ctrl_pkg::flash_pins_s pins,
    output logic [15:0] dq
);
    logic [2:0] mode = 3'h0; // 0 read 1 chip 2 window 3 erase 4 suspend
    logic [2:0] cyc = 3'h0; // Unlock sequence position
    logic [6:0] nsec = 7'h00; // Queued sectors
    int tmr = 0; // Window or erase time left
    logic tg = 1'h0; // Flips on every read
    logic we_q = 1'h1;
    logic [15:0] last = 16'h0000;
    logic [18:0] cmd;
    logic rd;
    logic [15:0] drv;
    logic [6:0] esec = 7'h00; // Sector held by the erase
    logic insec; // Read falls inside that sector
    assign cmd = {pins.addr[10:0], pins.dq_out[7:0]};
    assign rd = !pins.ce_b && !pins.oe_b;
    // Array data when idle, status while erasing
    assign insec = pins.addr[21:15] == esec;
    assign drv = (mode == 3'h0 || mode == 3'h4 && !insec) ? 16'h5A81 :
        {8'h00, mode == 3'h4, tg && mode != 3'h4, 2'h0, mode != 3'h2, tg,
        2'h0};
    // Released bus shows the inverse, never a stale copy
    assign dq = rd ? drv : ~last;
    // Expected unlock and setup words
    function automatic logic [18:0] step(input logic [2:0] c);
        case (c)
            3'h0, 3'h3: step = 19'h555AA; // 555 AA
            3'h1, 3'h4: step = 19'h2AA55; // 2AA 55
            default: step = 19'h55580; // 555 80
        endcase
    endfunction : step
    always @(negedge pins.oe_b) tg <= ~tg;
    // Commands act at the write strobe rise
    always @(posedge clk or negedge reset_b) begin
        if (!reset_b) begin
            mode <= 3'h0;
            cyc <= 3'h0;
            nsec <= 7'h00;
            esec <= 7'h00;
        end else begin
            we_q <= pins.we_b;
            if (rd) last <= drv;
            if (tmr > 0) tmr <= tmr - 1;
            if (mode == 3'h2 && tmr == 1) begin
                mode <= 3'h3;
                tmr <= 2000;
            end
            if ((mode == 3'h1 || mode == 3'h3) && tmr == 1) mode <= 3'h0;
            if (pins.we_b && !we_q && !pins.ce_b) begin
                if (mode == 3'h2) begin
                    if (cmd[7:0] == 8'h30) begin
                        nsec <= nsec + 7'h01;
                        tmr <= 500;
                    end else if (cmd[7:0] == 8'hB0) mode <= 3'h4;
                    else mode <= 3'h0;
                end else if (mode == 3'h3 && cmd[7:0] == 8'hB0) begin
                    mode <= 3'h4;
                end else if (mode == 3'h4 && cyc == 3'h0 && cmd[7:0] == 8'h30)
                begin
                    mode <= 3'h3;
                    tmr <= 2000;
                end else if (mode == 3'h0 || mode == 3'h4) begin
                    cyc <= (cmd == step(cyc)) ? cyc + 3'h1 : 3'h0;
                    if (cyc == 3'h5) begin
                        cyc <= 3'h0;
                        if (cmd == 19'h55510) mode <= 3'h1;
                        if (cmd[7:0] == 8'h30) mode <= 3'h2;
                        nsec <= 7'h01;
                        esec <= pins.addr[21:15];
                        tmr <= cmd[7:0] == 8'h10 ? 20000 : 500;
                    end
                end
            end
        end
    end
endmodule : flash_dev_model

// >>> tb/testbench.sv
`timescale 1ns/10ps
module testbench;
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
    logic [31:0] s_wdata = 32'h0, v;
    logic [3:0] s_wstrb = 4'hF;
    logic s_awvalid = 0, s_wvalid = 0, s_bready = 0;
    logic s_arvalid = 0, s_rready = 0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, flash_reset_b;
    logic [1:0] s_bresp, s_rresp, resp;
    logic [31:0] s_rdata;
    logic [15:0] flash_dq_in;
    flash_ctrl_pkg::flash_pins_s flash_pins;
    int failures = 0, checks_done = 0;
    always #50 clk = ~clk;
    flash_erase_ctrl dut_u (.clk, .rst_b, .s_awaddr, .s_awvalid, .s_awready,
        .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
        .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
        .s_rvalid, .s_rready, .flash_pins, .flash_dq_in, .flash_reset_b);
    flash_dev_model mdl (.clk, .reset_b(flash_reset_b), .pins(flash_pins),
        .dq(flash_dq_in));
    task automatic chk(input string n, input logic [31:0] s, e);
        checks_done++;
        if (s !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge clk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1;
        s_wvalid <= 1;
        s_bready <= 1;
        // Each channel is released at its own handshake
        do begin
            @(posedge clk);
            if (s_awvalid && s_awready) begin
                aw_done = 1'b1;
                s_awvalid <= 0;
            end
            if (s_wvalid && s_wready) begin
                w_done = 1'b1;
                s_wvalid <= 0;
            end
        end while (!(aw_done && w_done));
        do @(posedge clk); while (!s_bvalid);
        resp = s_bresp;
        s_bready <= 0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        s_araddr <= a;
        s_arvalid <= 1;
        s_rready <= 1;
        do @(posedge clk); while (!s_arready);
        s_arvalid <= 0;
        do @(posedge clk); while (!s_rvalid);
        v = s_rdata;
        resp = s_rresp;
        s_rready <= 0;
    endtask : rd
    // Order an operation, then poll until the controller is idle
    task automatic op(input logic [31:0] o);
        wr(8'h00, o);
        do rd(8'h10); while (v[0] !== 1'b0);
    endtask : op
    task automatic results;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : results
    // Whole run needs well under this span
    initial begin
        #(100 * 60000);
        failures++;
        results();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1;
        repeat (3) @(posedge clk);
        rd(8'h10);
        chk("status", v, 0);
        chk("rresp", resp, 0);
        wr(8'h20, 0);
        chk("bresp", resp, 2);
        rd(8'h20);
        chk("rresp", resp, 2);
        wr(8'h04, 32'h0003_8000);
        op(2);
        rd(8'h10);
        chk("window", v[2], 1);
        chk("mode", mdl.mode, 2);
        op(3);
        chk("sectors", mdl.nsec, 2);
        op(4);
        chk("mode", mdl.mode, 4);
        rd(8'h10);
        chk("window", v[2], 0);
        chk("suspended", v[7], 1);
        op(9);
        rd(8'h0C);
        chk("suspended sector", v[7:3], 5'h11);
        wr(8'h04, 0);
        op(9);
        rd(8'h0C);
        chk("other sector", v[15:0], 16'h5A81);
        wr(8'h04, 32'h0003_8000);
        op(5);
        op(5);
        chk("mode", mdl.mode, 3);
        op(6);
        chk("mode", mdl.mode, 3);
        op(4);
        chk("mode", mdl.mode, 4);
        op(10);
        chk("mode", mdl.mode, 0);
        op(3);
        rd(8'h10);
        chk("err", v[1], 1);
        wr(8'h10, 32'h0000_0002);
        rd(8'h10);
        chk("err cleared", v[1], 0);
        op(2);
        op(6);
        chk("mode", mdl.mode, 0);
        $display("sector erase test done");
        op(1);
        chk("mode", mdl.mode, 1);
        op(4);
        chk("mode", mdl.mode, 1);
        op(9);
        rd(8'h0C);
        chk("poll", v[7], 0);
        op(9);
        rd(8'h10);
        chk("toggle", v[4], 1);
        chk("erase toggle", v[5], 1);
        repeat (21000) @(posedge clk);
        op(9);
        rd(8'h0C);
        chk("array", v[15:0], 16'h5A81);
        $display("chip erase test done");
        results();
    end
endmodule : testbench
